// ### src/ctl_pkg.sv
package ctl_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0]  CTRL_ONE_OFF = 8'h00;   // bus_control_one
    localparam logic [15:0] CTRL_ONE_RST = 16'h0000;

    // ****************************************************************
    // bus constants
    // ****************************************************************
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;  // general call
    localparam logic [7:0] CRC8_POLY     = 8'h07;  // x^8 + x^2 + x + 1

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam longint LINK_PERIOD_PS = 15000;     // link clock period
    localparam longint TIMEOUT_NS     = 25000000;  // clock-low limit
    // longest time: round down, at least one cycle
    localparam longint TIMEOUT_RAW =
        (TIMEOUT_NS * 1000) / LINK_PERIOD_PS;
    localparam int TIMEOUT_CYC =
        (TIMEOUT_RAW < 1) ? 1 : int'(TIMEOUT_RAW);
    localparam int SYNC_STAGES = 2;       // level crossing depth
    localparam logic [4:0] RST_HOLD = 5'h10; // link reset stretch

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic soft_reset_hold;               // 15
        logic rsv14;                         // 14, reads zero
        logic alert_line_drive;              // 13
        logic pec_request;                   // 12
        logic acknowledge_position;          // 11
        logic acknowledge_enable;            // 10
        logic stop_request;                  // 9
        logic start_request;                 // 8
        logic stretch_disable;               // 7
        logic general_call_response_enable;  // 6
        logic error_check_enable;            // 5
        logic address_resolution_enable;     // 4
        logic mgmt_bus_role_select;          // 3
        logic rsv2;                          // 2, reads zero
        logic mgmt_bus_mode_select;          // 1
        logic module_enable;                 // 0
    } ctl_ctrl_s;

    // one toggle per link event, crossing to the core clock
    typedef struct packed {
        logic timeout;
        logic pec_sent;
        logic stop_sent;
        logic start_sent;
    } ctl_ev_s;

endpackage : ctl_pkg

// ### src/ctl_sync.sv
`timescale 1ns/1ps

// ********************************************************************
// multi-stage level synchroniser
// ********************************************************************
module ctl_sync #(
    parameter int W      = 1,
    parameter int STAGES = 2
) (
    input  wire logic         clk,  // destination clock
    input  wire logic [W-1:0] d,    // level from another domain
    output logic      [W-1:0] q     // synchronised level
);
    logic [STAGES-1:0][W-1:0] stage;
    logic [STAGES-1:0][W-1:0] next_stage;

    // shift chain; only the last stage leaves the module
    always_comb begin
        next_stage = {stage[STAGES-2:0], d};
    end

    // no reset: contents settle within STAGES edges
    always_ff @(posedge clk) begin
        stage <= next_stage;
    end

    assign q = stage[STAGES-1];

endmodule : ctl_sync

// ### src/ctl_one_reg.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps

module ctl_one_reg
    import ctl_pkg::*;
#(
    parameter int          TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter logic [6:0]  DEV_ADDR       = 7'h61,  // device default
    parameter logic [6:0]  HOST_ADDR      = 7'h08   // host address
) (
    // core side
    input  wire logic        core_clk,         // register clock
    input  wire logic        sys_rst,          // sync reset, high
    input  wire logic [7:0]  reg_addr,         // byte address
    input  wire logic [15:0] reg_wdata,        // write data
    input  wire logic        reg_wr,           // write strobe
    input  wire logic        reg_rd,           // read strobe
    output logic      [15:0] reg_rdata,        // read data, +1 cycle
    output ctl_ctrl_s        ctrl_word,        // live control bits
    output logic             timeout_error_flag, // one-cycle pulse
    // link side
    input  wire logic        link_clk,         // link clock
    input  wire logic        scl_in,           // clock pin level
    output logic             scl_out,          // clock pin value
    output logic             scl_oe_n,         // low: pull clock low
    output logic             alert_out,        // alert pin value
    output logic             alert_oe_n,       // low: pull alert low
    input  wire logic        start_sent,       // start went out
    input  wire logic        stop_sent,        // stop went out
    input  wire logic        pec_sent,         // check byte went out
    input  wire logic        bus_byte_valid,   // byte completed
    input  wire logic        bus_byte_is_addr, // byte is address
    input  wire logic [7:0]  bus_byte,         // byte on the bus
    input  wire logic        hold_req,         // target not ready
    output logic             ack_bit,          // 1: acknowledge
    output logic      [7:0]  pec_value,        // running crc
    output logic             addr_hit,         // resolution match
    output logic             gc_hit            // general call match
);

    localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [TO_W-1:0] TO_LIM = TO_W'(TIMEOUT_CYCLES - 1);

    // ****************************************************************
    // crc-8 step over one byte, msb first
    // ****************************************************************
    function automatic logic [7:0] crc8_step(
        input logic [7:0] crc,
        input logic [7:0] data
    );
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ CRC8_POLY)
                     : {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc8_step

    // ****************************************************************
    // state of the core domain
    // ****************************************************************
    typedef struct packed {
        ctl_ctrl_s   ctrl;        // bus_control_one
        logic [15:0] rdata;       // read data register
        ctl_ev_s     ev_seen;     // last toggles taken
        logic [4:0]  hold;        // link reset stretch count
        logic        link_reset;  // reset toward the link
        logic        to_pulse;    // timeout seen this cycle
    } ctl_core_s;

    // ****************************************************************
    // state of the link domain
    // ****************************************************************
    typedef struct packed {
        logic            scl3;      // third pin stage
        logic            scl_lvl;   // accepted clock level
        logic [TO_W-1:0] to_cnt;    // clock-low counter
        logic            to_fired;  // one timeout per low phase
        ctl_ev_s         ev;        // event toggles
        logic [7:0]      crc;       // running check value
        logic            ack_next;  // setting held for next byte
        logic            ack_bit;   // decision for last byte
        logic            addr_hit;  // resolution address seen
        logic            gc_hit;    // general call seen
        logic            scl_oe_n;  // stretch drive
        logic            alert_oe_n; // alert drive
    } ctl_link_s;

    ctl_core_s c;
    ctl_core_s next_c;
    ctl_link_s l;
    ctl_link_s next_l;

    ctl_ev_s   ev_sync;    // link toggles, in core clock
    ctl_ctrl_s ctrl_sync;  // control bits, in link clock
    logic      lrst_sync;  // link reset, in link clock
    logic      scl_s2;     // clock pin, second stage

    // ****************************************************************
    // crossings
    // ****************************************************************
    // event toggles into the core domain
    ctl_sync #(
        .W      ($bits(ctl_ev_s)),
        .STAGES (SYNC_STAGES)
    ) u_ev_sync (
        .clk (core_clk),
        .d   (l.ev),
        .q   (ev_sync)
    );

    // control bits are quasi-static; bits may land a cycle apart
    ctl_sync #(
        .W      ($bits(ctl_ctrl_s)),
        .STAGES (SYNC_STAGES)
    ) u_ctrl_sync (
        .clk (link_clk),
        .d   (c.ctrl),
        .q   (ctrl_sync)
    );

    // reset level for the link, driven from a core flop
    ctl_sync #(
        .W      (1),
        .STAGES (SYNC_STAGES)
    ) u_rst_sync (
        .clk (link_clk),
        .d   (c.link_reset),
        .q   (lrst_sync)
    );

    // clock pin: two stages here, the third in the link state
    ctl_sync #(
        .W      (1),
        .STAGES (SYNC_STAGES)
    ) u_scl_sync (
        .clk (link_clk),
        .d   (scl_in),
        .q   (scl_s2)
    );

    // ****************************************************************
    // core domain: register port and request bits
    // ****************************************************************
    always_comb begin
        ctl_ev_s ev;
        ev     = '0;
        next_c = c;

        // read data stand one cycle after the strobe
        next_c.rdata = '0;
        if (reg_rd && reg_addr == CTRL_ONE_OFF) begin
            next_c.rdata = c.ctrl;
        end

        // software write; reserved bits never store
        if (reg_wr && reg_addr == CTRL_ONE_OFF) begin
            next_c.ctrl      = reg_wdata;
            next_c.ctrl.rsv2  = 1'b0;
            next_c.ctrl.rsv14 = 1'b0;
        end

        // edges on the toggles; ignored while the link is reset
        next_c.ev_seen = ev_sync;
        if (!c.link_reset) begin
            ev = ev_sync ^ c.ev_seen;
        end

        // hardware clears come after the write so they win
        if (ev.start_sent) begin
            next_c.ctrl.start_request = 1'b0;
            next_c.ctrl.pec_request   = 1'b0;
        end
        if (ev.stop_sent) begin
            next_c.ctrl.stop_request = 1'b0;
            next_c.ctrl.pec_request  = 1'b0;
        end
        if (ev.pec_sent) begin
            next_c.ctrl.pec_request = 1'b0;
        end

        // a timeout sets stop even over a software clear
        if (ev.timeout) begin
            next_c.ctrl.stop_request = 1'b1;
        end
        next_c.to_pulse = ev.timeout;

        // disabling the module drops the per-transfer bits, stop_request excepted
        if (!next_c.ctrl.module_enable) begin
            next_c.ctrl.start_request        = 1'b0;
            next_c.ctrl.acknowledge_enable   = 1'b0;
            next_c.ctrl.acknowledge_position = 1'b0;
            next_c.ctrl.pec_request          = 1'b0;
            next_c.ctrl.alert_line_drive     = 1'b0;
        end

        // stretch the link reset so the slower clock sees it and
        // its toggles settle back to zero before edges count again
        if (c.ctrl.soft_reset_hold) begin
            next_c.hold = RST_HOLD;
        end else if (c.hold != '0) begin
            next_c.hold = c.hold - 5'h01;
        end
        next_c.link_reset = c.ctrl.soft_reset_hold
                          || (c.hold != '0);

        // synchronous reset; toggles are tracked, not zeroed
        if (sys_rst) begin
            next_c.ctrl       = CTRL_ONE_RST;
            next_c.rdata      = '0;
            next_c.ev_seen    = ev_sync;
            next_c.hold       = RST_HOLD;
            next_c.link_reset = 1'b1;
            next_c.to_pulse   = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        c <= next_c;
    end

    // ****************************************************************
    // link domain: pins, timeout, check, address and ack
    // ****************************************************************
    always_comb begin
        logic       en;
        logic [6:0] addr7;
        en     = ctrl_sync.module_enable;
        addr7  = bus_byte[7:1];
        next_l = l;

        // third pin stage; level changes once stages two and
        // three agree, which filters a one-cycle glitch
        next_l.scl3 = scl_s2;
        if (scl_s2 == l.scl3) begin
            next_l.scl_lvl = scl_s2;
        end

        // clock held low too long: one timeout per low phase
        if (!en || l.scl_lvl) begin
            next_l.to_cnt   = '0;
            next_l.to_fired = 1'b0;
        end else if (!l.to_fired) begin
            if (l.to_cnt == TO_LIM) begin
                next_l.to_fired   = 1'b1;
                next_l.ev.timeout = ~l.ev.timeout;
            end else begin
                next_l.to_cnt = l.to_cnt + 1'b1;
            end
        end

        // sent conditions become toggles for the core
        if (start_sent) begin
            next_l.ev.start_sent = ~l.ev.start_sent;
        end
        if (stop_sent) begin
            next_l.ev.stop_sent = ~l.ev.stop_sent;
        end
        if (pec_sent) begin
            next_l.ev.pec_sent = ~l.ev.pec_sent;
        end

        // check value restarts with each start condition and
        // covers every byte, address bytes included
        if (start_sent) begin
            next_l.crc = '0;
        end else if (bus_byte_valid && ctrl_sync.error_check_enable) begin
            next_l.crc = crc8_step(l.crc, bus_byte);
        end

        // address bytes: general call and resolution address
        if (bus_byte_valid && bus_byte_is_addr && en) begin
            next_l.gc_hit = ctrl_sync.general_call_response_enable
                          && addr7 == GEN_CALL_ADDR;
            next_l.addr_hit =
                ctrl_sync.mgmt_bus_mode_select
                && ctrl_sync.address_resolution_enable
                && addr7 == (ctrl_sync.mgmt_bus_role_select
                             ? HOST_ADDR : DEV_ADDR);
        end

        // data bytes: position picks current or held setting
        if (bus_byte_valid && !bus_byte_is_addr) begin
            next_l.ack_bit = ctrl_sync.acknowledge_position
                           ? l.ack_next
                           : ctrl_sync.acknowledge_enable;
            next_l.ack_next = ctrl_sync.acknowledge_enable;
        end
        if (!en) begin
            next_l.ack_bit  = 1'b0;
            next_l.ack_next = 1'b0;
            next_l.addr_hit = 1'b0;
            next_l.gc_hit   = 1'b0;
        end

        // stretch only as a target, only when allowed; never
        // stretch as host since the host owns the clock
        next_l.scl_oe_n = !(en && hold_req
                            && !ctrl_sync.stretch_disable
                            && !ctrl_sync.mgmt_bus_role_select);

        // alert is open drain: pull low to ask for attention
        next_l.alert_oe_n = !(en && ctrl_sync.alert_line_drive);

        // reset releases every pin and zeroes the toggles
        if (lrst_sync) begin
            next_l            = '0;
            next_l.scl3       = 1'b1;
            next_l.scl_lvl    = 1'b1;
            next_l.scl_oe_n   = 1'b1;
            next_l.alert_oe_n = 1'b1;
        end
    end

    always_ff @(posedge link_clk) begin
        l <= next_l;
    end

    // ****************************************************************
    // outputs, straight from flops except the two pin values tied low
    // ****************************************************************
    assign reg_rdata          = c.rdata;
    assign ctrl_word          = c.ctrl;
    assign timeout_error_flag = c.to_pulse;
    assign scl_out            = 1'b0;    // open drain drives low only
    assign scl_oe_n           = l.scl_oe_n;
    assign alert_out          = 1'b0;    // open drain drives low only
    assign alert_oe_n         = l.alert_oe_n;
    assign ack_bit            = l.ack_bit;
    assign pec_value          = l.crc;
    assign addr_hit           = l.addr_hit;
    assign gc_hit             = l.gc_hit;

endmodule : ctl_one_reg

// ### tb/ctl_one_reg_sva.sv
`timescale 1ns/1ps

// ********************************************************************
// control register checker
// ********************************************************************
module ctl_one_reg_sva
    import ctl_pkg::*;
(
    input wire logic        core_clk,           // register clock
    input wire logic        sys_rst,            // sync reset, high
    input wire logic        link_clk,           // link clock
    input wire logic [7:0]  reg_addr,           // byte address
    input wire logic [15:0] reg_wdata,          // write data
    input wire logic        reg_wr,             // write strobe
    input wire logic        reg_rd,             // read strobe
    input wire logic [15:0] reg_rdata,          // read data
    input ctl_ctrl_s        ctrl_word,          // live control bits
    input wire logic        timeout_error_flag, // timeout pulse
    input wire logic        scl_out,            // clock pin value
    input wire logic        alert_out           // alert pin value
);
    // software-only fields follow the written word
    property p_wr_keep;
        @(posedge core_clk) disable iff (sys_rst)
        reg_wr && reg_addr == CTRL_ONE_OFF |=>
            {ctrl_word.soft_reset_hold, ctrl_word[7:3], ctrl_word[1:0]} ==
            {$past(reg_wdata[15]), $past(reg_wdata[7:3]),
             $past(reg_wdata[1:0])};
    endproperty
    a_wr_keep: assert property (p_wr_keep)
        else $error("control field differs from written word");
    property p_rsv;
        @(posedge core_clk) disable iff (sys_rst)
        !ctrl_word.rsv2 && !ctrl_word.rsv14;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved control bit set");
    property p_rd;
        @(posedge core_clk) disable iff (sys_rst)
        reg_rd && reg_addr == CTRL_ONE_OFF |=>
            reg_rdata == $past(ctrl_word);
    endproperty
    a_rd: assert property (p_rd)
        else $error("read data differs from control word");
    property p_unmapped;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_rd && reg_addr != CTRL_ONE_OFF) || !reg_rd |=>
            reg_rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("read data not zero");
    property p_dis;
        @(posedge core_clk) disable iff (sys_rst)
        !ctrl_word.module_enable |-> !(ctrl_word.start_request ||
            ctrl_word.acknowledge_enable ||
            ctrl_word.acknowledge_position ||
            ctrl_word.pec_request || ctrl_word.alert_line_drive);
    endproperty
    a_dis: assert property (p_dis)
        else $error("request bit kept while disabled");
    property p_to_stop;
        @(posedge core_clk) disable iff (sys_rst)
        timeout_error_flag |-> ##[0:2] ctrl_word.stop_request;
    endproperty
    a_to_stop: assert property (p_to_stop)
        else $error("timeout did not set stop request");
    property p_to_pulse;
        @(posedge core_clk) disable iff (sys_rst)
        timeout_error_flag |=> !timeout_error_flag;
    endproperty
    a_to_pulse: assert property (p_to_pulse)
        else $error("timeout flag longer than one cycle");
    // open-drain values never drive high
    property p_pins;
        @(posedge link_clk) disable iff (sys_rst)
        scl_out == 1'b0 && alert_out == 1'b0;
    endproperty
    a_pins: assert property (p_pins)
        else $error("pin value not low");
    c_wr: cover property (@(posedge core_clk) reg_wr && reg_wdata[0]);
    c_rd: cover property (@(posedge core_clk) reg_rd && reg_addr != 8'h00);
    c_to: cover property (@(posedge core_clk) timeout_error_flag);
endmodule : ctl_one_reg_sva

bind ctl_one_reg ctl_one_reg_sva u_sva (
    .core_clk(core_clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl_word(ctrl_word),
    .timeout_error_flag(timeout_error_flag), .scl_out(scl_out),
    .alert_out(alert_out)
);

// ### tb/ctl_far_end.sv
`timescale 1ns/1ps

// ********************************************************************
// far side of the bus: events, bytes and a clock-low holder
// ********************************************************************
module ctl_far_end (
    input  wire logic       link_clk,   // link clock
    input  wire logic       scl_oe_n,   // low: block pulls clock
    output logic            scl_in,     // wired clock level
    output logic [2:0]      ev,         // pec, stop, start pulses
    output logic            valid,      // byte done
    output logic            is_addr,    // byte is address
    output logic [7:0]      data        // byte value
);
    logic hold = 1'b0;
    initial begin
        ev      = 3'h0;
        valid   = 1'b0;
        is_addr = 1'b0;
        data    = 8'h00;
    end
    // pull-up: low while anyone pulls
    assign scl_in = scl_oe_n && !hold;
    // one-cycle event pulse, bit 0 start, 1 stop, 2 pec
    task automatic pulse(input logic [2:0] m);
        @(posedge link_clk) ev <= m;
        @(posedge link_clk) ev <= 3'h0;
    endtask : pulse
    task automatic send(input logic a, input logic [7:0] b);
        @(posedge link_clk) begin
            valid   <= 1'b1;
            is_addr <= a;
            data    <= b;
        end
        @(posedge link_clk) valid <= 1'b0;
    endtask : send
    // stuck-low clock, longer than the limit
    task automatic hold_low(input int n);
        @(posedge link_clk) hold <= 1'b1;
        repeat (n) @(posedge link_clk);
        hold <= 1'b0;
    endtask : hold_low
endmodule : ctl_far_end

// ### tb/testbench.sv
`timescale 1ns/1ps

module testbench;
    import ctl_pkg::*;
    localparam logic [6:0] DEV  = 7'h61;
    localparam logic [6:0] HOST = 7'h08;
    logic        core_clk  = 1'b0;
    logic        link_clk  = 1'b0;
    logic        sys_rst   = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        hold_req  = 1'b0;
    logic [15:0] reg_rdata;
    ctl_ctrl_s   ctrl_word;
    logic        tmo, scl_in, scl_oe_n, alert_oe_n, ack_bit;
    logic        valid, is_addr, addr_hit, gc_hit, scl_out, alert_out;
    logic [2:0]  ev;
    logic [7:0]  data, pec_value;
    int          err_total = 0;
    int          cmp_count = 0;
    int          tmo_seen  = 0;

    // one count per timeout pulse
    always @(posedge core_clk) if (tmo === 1'b1) tmo_seen++;

    initial forever #5 core_clk = ~core_clk;
    // unrelated phase to the core clock
    initial begin
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end

    ctl_one_reg #(.TIMEOUT_CYCLES(20))
    dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ctrl_word(ctrl_word),
        .timeout_error_flag(tmo), .link_clk(link_clk), .scl_in(scl_in),
        .scl_out(scl_out), .scl_oe_n(scl_oe_n), .alert_out(alert_out),
        .alert_oe_n(alert_oe_n), .start_sent(ev[0]), .stop_sent(ev[1]),
        .pec_sent(ev[2]), .bus_byte_valid(valid),
        .bus_byte_is_addr(is_addr), .bus_byte(data), .hold_req(hold_req),
        .ack_bit(ack_bit), .pec_value(pec_value), .addr_hit(addr_hit),
        .gc_hit(gc_hit)
    );
    ctl_far_end far (
        .link_clk(link_clk), .scl_oe_n(scl_oe_n), .scl_in(scl_in),
        .ev(ev), .valid(valid), .is_addr(is_addr), .data(data)
    );

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk) begin
            reg_wr    <= 1'b1;
            reg_addr  <= a;
            reg_wdata <= d;
        end
        @(posedge core_clk) reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge core_clk) begin
            reg_rd   <= 1'b1;
            reg_addr <= a;
        end
        @(posedge core_clk) reg_rd <= 1'b0;
        #1 chk("reg_rdata", e, reg_rdata);
    endtask : rd
    // long enough for both crossings and the link flops
    task automatic settle();
        repeat (15) @(posedge core_clk);
    endtask : settle
    function automatic logic [7:0] crc(input logic [7:0] c,
                                       input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ CRC8_POLY
                                              : {r[6:0], 1'b0};
        return r;
    endfunction : crc

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs();
        rd(8'h00, 16'h0000);
        wr(8'h00, 16'hffff);
        rd(8'h00, 16'hbffb);
        wr(8'h00, 16'h0000);
        wr(8'h04, 16'h0041);
        rd(8'h04, 16'h0000);
        rd(8'h00, 16'h0000);
        wr(8'h00, 16'h3f00);
        rd(8'h00, 16'h0200);
    endtask : t_regs
    task automatic t_events();
        wr(8'h00, 16'h1301);
        repeat (30) @(posedge core_clk);
        far.pulse(3'b001);
        settle();
        rd(8'h00, 16'h0201);
        far.pulse(3'b010);
        settle();
        rd(8'h00, 16'h0001);
        wr(8'h00, 16'h1001);
        far.pulse(3'b100);
        settle();
        rd(8'h00, 16'h0001);
    endtask : t_events
    task automatic t_match();
        wr(8'h00, 16'h0041);
        settle();
        far.send(1'b1, 8'h00);
        settle();
        chk("gc_hit", 16'h0001, {15'h0, gc_hit});
        wr(8'h00, 16'h0013);
        settle();
        far.send(1'b1, 8'h00);
        far.send(1'b1, {DEV, 1'b0});
        settle();
        chk("gc_hit", 16'h0000, {15'h0, gc_hit});
        chk("addr_hit", 16'h0001, {15'h0, addr_hit});
        wr(8'h00, 16'h001b);
        settle();
        far.send(1'b1, {HOST, 1'b0});
        settle();
        chk("addr_hit", 16'h0001, {15'h0, addr_hit});
        far.send(1'b1, {DEV, 1'b0});
        settle();
        chk("addr_hit", 16'h0000, {15'h0, addr_hit});
    endtask : t_match
    task automatic t_ack_pec();
        wr(8'h00, 16'h0421);
        settle();
        far.pulse(3'b001);
        far.send(1'b1, 8'ha0);
        far.send(1'b0, 8'h5c);
        settle();
        chk("ack_bit", 16'h0001, {15'h0, ack_bit});
        chk("pec", {8'h0, crc(crc(8'h00, 8'ha0), 8'h5c)},
            {8'h0, pec_value});
        wr(8'h00, 16'h0801);
        settle();
        far.send(1'b0, 8'h33);
        settle();
        chk("ack_bit", 16'h0001, {15'h0, ack_bit});
        far.send(1'b0, 8'h34);
        settle();
        chk("ack_bit", 16'h0000, {15'h0, ack_bit});
    endtask : t_ack_pec
    task automatic t_pins();
        wr(8'h00, 16'h2001);
        settle();
        chk("alert_oe_n", 16'h0000, {14'h0, alert_out, alert_oe_n});
        wr(8'h00, 16'h0001);
        settle();
        chk("alert_oe_n", 16'h0001, {15'h0, alert_oe_n});
        far.hold_low(40);
        settle();
        rd(8'h00, 16'h0201);
        chk("tmo_seen", 16'h0001, 16'(tmo_seen));
        @(posedge link_clk) hold_req <= 1'b1;
        settle();
        chk("scl_oe_n", 16'h0000, {14'h0, scl_out, scl_oe_n});
        wr(8'h00, 16'h0081);
        settle();
        chk("scl_oe_n", 16'h0001, {15'h0, scl_oe_n});
        // far side already idle and released before the hold
        wr(8'h00, 16'h8001);
        settle();
        chk("scl_oe_n", 16'h0001, {15'h0, scl_oe_n});
    endtask : t_pins

    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (30) @(posedge core_clk);
        t_regs();
        t_events();
        t_match();
        t_ack_pec();
        t_pins();
        final_report();
    end
    // generous bound on the whole sequence
    initial begin
        #200000;
        err_total++;
        final_report();
    end
endmodule : testbench
